// ### include/mcd_consts.vh
// Constants for the MIDI control decoder
`ifndef MCD_CONSTS_VH
`define MCD_CONSTS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define MCD_CLK_NS 4
`define MCD_BIT_NS 32000
`define MCD_FLASH_MS 200
`define MCD_NS_PER_MS 1000000

// ----------------------------------------
// MIDI status bytes
// ----------------------------------------
`define MCD_ST_CC 4'hB
`define MCD_ST_PROG 4'hC
`define MCD_ST_PRESS 4'hD
`define MCD_ST_SYS 4'hF
`define MCD_RT_MIN 8'hF8
`define MCD_RT_CLOCK 8'hF8
`define MCD_SX_START 8'hF0
`define MCD_SX_END 8'hF7
`define MCD_CH_ONE 4'h0

// ----------------------------------------
// Controller numbers
// ----------------------------------------
`define MCD_CC_LEVEL 7'h07
`define MCD_CC_TIME 7'h0C
`define MCD_CC_FEEDBACK 7'h0D
`define MCD_CC_MIX 7'h0E
`define MCD_CC_RATE 7'h0F
`define MCD_CC_DEPTH 7'h10
`define MCD_CC_LSB_BIT 5
`define MCD_CC_WAVE 7'h66
`define MCD_CC_RANGE 7'h56
`define MCD_CC_BYPASS 7'h50
`define MCD_CC_MODE_MIN 7'h78
`define MCD_HALF_BIT 6
`define MCD_WAVE_MAX 3'h6
`define MCD_NPARAM 6
`define MCD_IDX_TIME 3'h1

// ----------------------------------------
// Lamp colours
// ----------------------------------------
`define MCD_LAMP_RED 3'h1
`define MCD_LAMP_GREEN 3'h2
`define MCD_LAMP_ORANGE 3'h3
`define MCD_LAMP_YELLOW 3'h4

// ----------------------------------------
// Register map and reset values
// ----------------------------------------
`define MCD_REG_CTRL 8'h00
`define MCD_REG_STATUS 8'h04
`define MCD_REG_CLKCNT 8'h08
`define MCD_REG_PARAM0 8'h10
`define MCD_REG_PARAM5 8'h24
`define MCD_CTRL_EN_BIT 0
`define MCD_CTRL_RESET 1'b1
`define MCD_EFFECT_RESET 1'b1

`endif

// ### rtl/mcd_top.v
// MIDI receive decoder: channel learn, realtime clock and sysex pass, CC to parameters
`timescale 1ns/1ps
`include "mcd_consts.vh"

module mcd_top #(
    parameter BIT_CYCLES = `MCD_BIT_NS / `MCD_CLK_NS,
    parameter FLASH_CYCLES = `MCD_FLASH_MS * (`MCD_NS_PER_MS / `MCD_CLK_NS)
) (
    // Clock and reset
    input wire clk_sys,
    input wire rstn,
    // MIDI input line
    input wire midi_rx,
    // Panel switches and tap state
    input wire tap_sw,
    input wire defeat_sw,
    input wire tap_tempo_active,
    // Panel control settings
    input wire [13:0] panel_level,
    input wire [13:0] panel_time,
    input wire [13:0] panel_feedback,
    input wire [13:0] panel_mix,
    input wire [13:0] panel_rate,
    input wire [13:0] panel_depth,
    // Nonvolatile channel store
    input wire nv_ready,
    input wire [3:0] nv_channel,
    output reg nv_write_reg,
    output reg [3:0] nv_data_reg,
    // Effective parameters
    output reg [13:0] level_out_reg,
    output reg [13:0] time_out_reg,
    output reg [13:0] feedback_out_reg,
    output reg [13:0] mix_out_reg,
    output reg [13:0] rate_out_reg,
    output reg [13:0] depth_out_reg,
    output reg [2:0] waveform_reg,
    output reg range_fast_reg,
    output reg effect_active_reg,
    output reg [2:0] delay_indicator_lamp_reg,
    // Realtime and system exclusive
    output reg clock_tick_reg,
    output reg sysex_valid_reg,
    output reg [7:0] sysex_data_reg,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata
);

// ----------------------------------------
// Functions
// ----------------------------------------
// Map a controller to a 14-bit slot: bit 3 hit, bits 2:0 index
function [3:0] slot_of;
    input [6:0] cc;
    reg [6:0] base;
    begin
        base = cc & ~(7'h01 << `MCD_CC_LSB_BIT);
        case (base)
            `MCD_CC_LEVEL: slot_of = 4'h8;
            `MCD_CC_TIME: slot_of = 4'h9;
            `MCD_CC_FEEDBACK: slot_of = 4'hA;
            `MCD_CC_MIX: slot_of = 4'hB;
            `MCD_CC_RATE: slot_of = 4'hC;
            `MCD_CC_DEPTH: slot_of = 4'hD;
            default: slot_of = 4'h0;
        endcase
    end
endfunction

// ----------------------------------------
// Byte receiver
// ----------------------------------------
wire rx_valid;
wire [7:0] rx_byte;

mcd_uart_rx #(
    .BIT_CYCLES(BIT_CYCLES)
) u_rx (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .rx_line(midi_rx),
    .byte_valid_reg(rx_valid),
    .byte_data_reg(rx_byte)
);

// ----------------------------------------
// Message framing
// ----------------------------------------
reg [7:0] run_status_reg;
reg have1_reg;
reg [6:0] d1_reg;
reg in_sysex_reg;

wire is_rt = rx_valid && (rx_byte >= `MCD_RT_MIN);
wire is_status = rx_valid && rx_byte[7] && !is_rt;
wire is_data = rx_valid && !rx_byte[7];
wire one_data = (run_status_reg[7:4] == `MCD_ST_PROG) || (run_status_reg[7:4] == `MCD_ST_PRESS);
wire chan_data = is_data && !in_sysex_reg && run_status_reg[7];
wire msg_done = chan_data && (have1_reg || one_data);
wire [6:0] msg_d1 = have1_reg ? d1_reg : rx_byte[6:0];
wire [6:0] msg_d2 = rx_byte[6:0];

// Running status is kept across data; system common cancels it
always @(posedge clk_sys)
begin
    if (!rstn)
    begin
        run_status_reg <= 8'h00;
        have1_reg <= 1'b0;
        d1_reg <= 7'h00;
        in_sysex_reg <= 1'b0;
    end
    else if (is_status)
    begin
        run_status_reg <= (rx_byte[7:4] == `MCD_ST_SYS) ? 8'h00 : rx_byte;
        have1_reg <= 1'b0;
        in_sysex_reg <= (rx_byte == `MCD_SX_START);
    end
    else if (chan_data)
    begin
        have1_reg <= !have1_reg && !one_data;
        d1_reg <= rx_byte[6:0];
    end
end

// ----------------------------------------
// Realtime clock and system exclusive
// ----------------------------------------
reg [15:0] clk_count_reg;

always @(posedge clk_sys)
begin
    if (!rstn)
    begin
        clock_tick_reg <= 1'b0;
        clk_count_reg <= 16'h0000;
        sysex_valid_reg <= 1'b0;
        sysex_data_reg <= 8'h00;
    end
    else
    begin
        // No channel check on these
        clock_tick_reg <= is_rt && (rx_byte == `MCD_RT_CLOCK);
        if (is_rt && (rx_byte == `MCD_RT_CLOCK))
            clk_count_reg <= clk_count_reg + 16'h0001;
        sysex_valid_reg <= (is_data && in_sysex_reg) || (is_status && (rx_byte == `MCD_SX_START))
            || (is_status && in_sysex_reg && (rx_byte == `MCD_SX_END));
        if (rx_valid)
            sysex_data_reg <= rx_byte;
    end
end

// ----------------------------------------
// Receive channel and learn
// ----------------------------------------
reg [3:0] chan_reg;
reg restored_reg;
reg enable_reg;
reg [25:0] flash_cnt_reg;

wire is_cc = msg_done && (run_status_reg[7:4] == `MCD_ST_CC);
wire is_mode = is_cc && (msg_d1 >= `MCD_CC_MODE_MIN);
wire learn = is_mode && tap_sw && defeat_sw;
wire on_chan = (run_status_reg[3:0] == chan_reg) && enable_reg;
wire cc_act = is_cc && !is_mode && on_chan;
wire [3:0] slot = slot_of(msg_d1);
wire lsb_msg = msg_d1[`MCD_CC_LSB_BIT];

always @(posedge clk_sys)
begin
    if (!rstn)
    begin
        chan_reg <= `MCD_CH_ONE;
        restored_reg <= 1'b0;
        nv_write_reg <= 1'b0;
        nv_data_reg <= `MCD_CH_ONE;
        flash_cnt_reg <= 26'h0000000;
    end
    else
    begin
        nv_write_reg <= 1'b0;
        if (learn)
        begin
            chan_reg <= run_status_reg[3:0];
            restored_reg <= 1'b1;
            nv_write_reg <= 1'b1;
            nv_data_reg <= run_status_reg[3:0];
            flash_cnt_reg <= FLASH_CYCLES[25:0];
        end
        else
        begin
            if (nv_ready && !restored_reg)
            begin
                chan_reg <= nv_channel;
                restored_reg <= 1'b1;
            end
            if (flash_cnt_reg != 26'h0000000)
                flash_cnt_reg <= flash_cnt_reg - 26'h0000001;
        end
    end
end

// ----------------------------------------
// Parameter ownership and values
// ----------------------------------------
reg [13:0] mval_reg [0:5];
reg [6:0] msb_reg [0:5];
reg [13:0] prev_reg [0:5];
reg [13:0] out_reg [0:5];
reg [5:0] owned_reg;
wire [13:0] panel_w [0:5];
integer i;

assign panel_w[0] = panel_level;
assign panel_w[1] = panel_time;
assign panel_w[2] = panel_feedback;
assign panel_w[3] = panel_mix;
assign panel_w[4] = panel_rate;
assign panel_w[5] = panel_depth;

always @(posedge clk_sys)
begin
    if (!rstn)
    begin
        owned_reg <= 6'h00;
        for (i = 0; i < `MCD_NPARAM; i = i + 1)
        begin
            mval_reg[i] <= 14'h0000;
            msb_reg[i] <= 7'h00;
            prev_reg[i] <= 14'h0000;
            out_reg[i] <= 14'h0000;
        end
    end
    else
    begin
        for (i = 0; i < `MCD_NPARAM; i = i + 1)
        begin
            prev_reg[i] <= panel_w[i];
            // A CC in the same cycle as a knob move wins
            if (cc_act && slot[3] && (slot[2:0] == i[2:0]))
            begin
                owned_reg[i] <= 1'b1;
                if (lsb_msg)
                    mval_reg[i] <= {msb_reg[i], msg_d2};
                else
                begin
                    msb_reg[i] <= msg_d2;
                    mval_reg[i] <= {msg_d2, 7'h00};
                end
            end
            else if (panel_w[i] != prev_reg[i])
                owned_reg[i] <= 1'b0;
            out_reg[i] <= owned_reg[i] ? mval_reg[i] : panel_w[i];
        end
    end
end

always @*
begin
    level_out_reg = out_reg[0];
    time_out_reg = out_reg[1];
    feedback_out_reg = out_reg[2];
    mix_out_reg = out_reg[3];
    rate_out_reg = out_reg[4];
    depth_out_reg = out_reg[5];
end

// ----------------------------------------
// Switch-type controllers and lamp
// ----------------------------------------
always @(posedge clk_sys)
begin
    if (!rstn)
    begin
        waveform_reg <= 3'h0;
        range_fast_reg <= 1'b0;
        effect_active_reg <= `MCD_EFFECT_RESET;
        delay_indicator_lamp_reg <= `MCD_LAMP_RED;
    end
    else
    begin
        // Other controller numbers fall through untouched
        if (cc_act && (msg_d1 == `MCD_CC_WAVE))
            waveform_reg <= (msg_d2[6:4] > `MCD_WAVE_MAX) ? `MCD_WAVE_MAX : msg_d2[6:4];
        if (cc_act && (msg_d1 == `MCD_CC_RANGE))
            range_fast_reg <= msg_d2[`MCD_HALF_BIT];
        if (cc_act && (msg_d1 == `MCD_CC_BYPASS))
            effect_active_reg <= msg_d2[`MCD_HALF_BIT];
        if (flash_cnt_reg != 26'h0000000)
            delay_indicator_lamp_reg <= `MCD_LAMP_YELLOW;
        else if (!effect_active_reg)
            delay_indicator_lamp_reg <= `MCD_LAMP_RED;
        else if (owned_reg[`MCD_IDX_TIME])
            delay_indicator_lamp_reg <= `MCD_LAMP_ORANGE;
        else if (tap_tempo_active)
            delay_indicator_lamp_reg <= `MCD_LAMP_GREEN;
        else
            delay_indicator_lamp_reg <= `MCD_LAMP_RED;
    end
end

// ----------------------------------------
// AHB-Lite slave, zero wait states
// ----------------------------------------
reg wr_pend_reg;
reg [7:0] wr_addr_reg;
wire take = hsel && hready && htrans[1];
wire [7:0] ra = haddr[7:0];
wire [2:0] pidx = ra[4:2] - 3'h4;

// Read mux sampled in the address phase so data stands in the data phase
always @(posedge clk_sys)
begin
    if (!rstn)
    begin
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        hrdata <= 32'h00000000;
        wr_pend_reg <= 1'b0;
        wr_addr_reg <= 8'h00;
        enable_reg <= `MCD_CTRL_RESET;
    end
    else
    begin
        if (wr_pend_reg && (wr_addr_reg == `MCD_REG_CTRL))
            enable_reg <= hwdata[`MCD_CTRL_EN_BIT];
        wr_pend_reg <= take && hwrite;
        wr_addr_reg <= ra;
        if (take && !hwrite)
        begin
            if (ra == `MCD_REG_CTRL)
                hrdata <= {31'h00000000, enable_reg};
            else if (ra == `MCD_REG_STATUS)
                hrdata <= {16'h0000, tap_tempo_active, owned_reg, waveform_reg,
                    range_fast_reg, effect_active_reg, chan_reg};
            else if (ra == `MCD_REG_CLKCNT)
                hrdata <= {16'h0000, clk_count_reg};
            else if ((ra >= `MCD_REG_PARAM0) && (ra <= `MCD_REG_PARAM5) && (ra[1:0] == 2'h0))
                hrdata <= {17'h00000, owned_reg[pidx], out_reg[pidx]};
            else
                hrdata <= 32'h00000000;
        end
    end
end

endmodule

// ### rtl/mcd_uart_rx.v
// Serial byte receiver for the MIDI input line
`timescale 1ns/1ps
`include "mcd_consts.vh"

module mcd_uart_rx #(
    parameter BIT_CYCLES = `MCD_BIT_NS / `MCD_CLK_NS
) (
    // Clock and reset
    input wire clk_sys,
    input wire rstn,
    // Serial line, idle high
    input wire rx_line,
    // Received byte
    output reg byte_valid_reg,
    output reg [7:0] byte_data_reg
);

// Counts are worked out at full width, then cut to the 16-bit counter on purpose
localparam integer BIT_M1_I = BIT_CYCLES - 1;
localparam integer HALF_M1_I = BIT_CYCLES / 2 - 1;
localparam [15:0] BIT_M1 = BIT_M1_I[15:0];
localparam [15:0] HALF_M1 = HALF_M1_I[15:0];
localparam [1:0] S_IDLE = 2'h0;
localparam [1:0] S_START = 2'h1;
localparam [1:0] S_DATA = 2'h2;
localparam [1:0] S_STOP = 2'h3;

reg [1:0] state_reg;
reg [15:0] cnt_reg;
reg [2:0] bit_reg;
reg [7:0] shift_reg;

always @(posedge clk_sys)
begin
    if (!rstn)
    begin
        state_reg <= S_IDLE;
        cnt_reg <= 16'h0000;
        bit_reg <= 3'h0;
        shift_reg <= 8'h00;
        byte_valid_reg <= 1'b0;
        byte_data_reg <= 8'h00;
    end
    else
    begin
        byte_valid_reg <= 1'b0;
        case (state_reg)
            S_IDLE:
            begin
                cnt_reg <= 16'h0000;
                if (!rx_line)
                    state_reg <= S_START;
            end
            S_START:
            begin
                // Sample mid start bit; a short glitch returns to idle
                if (cnt_reg == HALF_M1)
                begin
                    cnt_reg <= 16'h0000;
                    bit_reg <= 3'h0;
                    state_reg <= rx_line ? S_IDLE : S_DATA;
                end
                else
                    cnt_reg <= cnt_reg + 16'h0001;
            end
            S_DATA:
            begin
                if (cnt_reg == BIT_M1)
                begin
                    cnt_reg <= 16'h0000;
                    shift_reg <= {rx_line, shift_reg[7:1]};
                    bit_reg <= bit_reg + 3'h1;
                    if (bit_reg == 3'h7)
                        state_reg <= S_STOP;
                end
                else
                    cnt_reg <= cnt_reg + 16'h0001;
            end
            S_STOP:
            begin
                // Framing errors drop the byte silently
                if (cnt_reg == BIT_M1)
                begin
                    state_reg <= S_IDLE;
                    byte_valid_reg <= rx_line;
                    byte_data_reg <= shift_reg;
                end
                else
                    cnt_reg <= cnt_reg + 16'h0001;
            end
            default:
                state_reg <= S_IDLE;
        endcase
    end
end

endmodule

// ### test/mcd_checker.sv
// Concurrent checks on the MIDI decoder's ports
`timescale 1ns/1ps
`include "mcd_consts.vh"

module mcd_checker #(
    parameter FLASH_CYCLES = 20
) (
    // Clock and reset
    input wire clk_sys,
    input wire rstn,
    // Panel input watched
    input wire [13:0] panel_time,
    // Outputs watched
    input wire nv_write_reg,
    input wire [3:0] nv_data_reg,
    input wire [13:0] time_out_reg,
    input wire [2:0] waveform_reg,
    input wire effect_active_reg,
    input wire [2:0] delay_indicator_lamp_reg,
    input wire clock_tick_reg,
    input wire sysex_valid_reg,
    input wire hreadyout,
    input wire hresp
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    // Counts yellow cycles so a lamp stuck on yellow is caught
    logic [31:0] yellow_cnt_reg;
    always_ff @(posedge clk_sys)
    begin
        if (!rstn || delay_indicator_lamp_reg != `MCD_LAMP_YELLOW)
            yellow_cnt_reg <= 32'h0;
        else
            yellow_cnt_reg <= yellow_cnt_reg + 32'h1;
    end

    sequence s_yellow_hold;
        (delay_indicator_lamp_reg == `MCD_LAMP_YELLOW) [*8];
    endsequence

    a_bus_always_ready: assert property (hreadyout && !hresp) else $error("bus slave stalled or errored");
    a_tick_one_cycle: assert property (clock_tick_reg |=> !clock_tick_reg) else $error("tick too long");
    a_sysex_one_cycle: assert property (sysex_valid_reg |=> !sysex_valid_reg) else $error("sysex too long");
    a_store_pulse_once: assert property (nv_write_reg |=> !nv_write_reg && $stable(nv_data_reg))
        else $error("store pulse too long");
    a_learn_flash_yellow: assert property (nv_write_reg |-> ##[0:2] s_yellow_hold)
        else $error("no yellow flash after learn");
    a_flash_length_bound: assert property (yellow_cnt_reg <= FLASH_CYCLES + 1)
        else $error("yellow flash too long");
    a_wave_code_range: assert property (waveform_reg <= `MCD_WAVE_MAX) else $error("bad wave code");
    a_panel_takes_back: assert property ($changed(panel_time) |-> ##[1:2] time_out_reg == panel_time)
        else $error("time not following panel");
    a_bypass_lamp_red: assert property ($fell(effect_active_reg) |-> ##[0:2]
        delay_indicator_lamp_reg inside {`MCD_LAMP_RED, `MCD_LAMP_YELLOW}) else $error("lamp not red");
    a_reset_state_out: assert property ($rose(rstn) |-> effect_active_reg && !nv_write_reg
        && delay_indicator_lamp_reg == `MCD_LAMP_RED) else $error("bad state after reset");
endmodule

bind mcd_top mcd_checker #(.FLASH_CYCLES(FLASH_CYCLES)) chk (.clk_sys(clk_sys), .rstn(rstn),
    .panel_time(panel_time), .nv_write_reg(nv_write_reg), .nv_data_reg(nv_data_reg),
    .time_out_reg(time_out_reg), .waveform_reg(waveform_reg), .effect_active_reg(effect_active_reg),
    .delay_indicator_lamp_reg(delay_indicator_lamp_reg), .clock_tick_reg(clock_tick_reg),
    .sysex_valid_reg(sysex_valid_reg), .hreadyout(hreadyout), .hresp(hresp));

// ### test/mcd_midi_src.sv
// MIDI sender model standing in for a controller or sequencer
`timescale 1ns/1ps

module mcd_midi_src #(
    parameter BIT_CYCLES = 16
) (
    // Clock
    input wire clk_sys,
    // Serial line toward the decoder, idle high
    output logic midi_line
);
    initial midi_line = 1'b1;

    // One 8N1 frame; the line returns to its idle high level afterwards
    task automatic send(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            midi_line <= frame[i];
            repeat (BIT_CYCLES) @(posedge clk_sys);
        end
    endtask

    // Controller change; data bytes never carry bit 7
    task automatic cc(input logic [3:0] ch, input logic [6:0] num, input logic [6:0] val);
        send({`MCD_ST_CC, ch});
        send({1'b0, num});
        send({1'b0, val});
    endtask
endmodule

// ### test/tb.sv
// Self-checking bench for the MIDI decoder
`timescale 1ns/1ps
`include "mcd_consts.vh"

module tb;
    localparam int BITC = 16;
    logic clk_sys, rstn, tap_sw, defeat_sw, tap_act, nv_ready, hsel, hwrite;
    logic [3:0] nv_channel;
    logic [13:0] panel [6];
    logic [13:0] outv [6];
    logic [13:0] keep [6];
    logic [31:0] haddr, hwdata, seed, rd, r;
    logic [1:0] htrans;
    logic [6:0] m, l;
    logic [6:0] ccn [6] = '{7'h07, 7'h0C, 7'h0D, 7'h0E, 7'h0F, 7'h10};
    wire midi_rx, nv_write, hreadyout, hresp, rng, eff, tick, sxv;
    wire [3:0] nv_data;
    wire [2:0] wave, lamp;
    wire [7:0] sxd;
    wire [31:0] hrdata;
    int failures, checks, ticks, sxn, nvw;

    mcd_top #(.BIT_CYCLES(BITC), .FLASH_CYCLES(20)) dut (.clk_sys(clk_sys), .rstn(rstn), .midi_rx(midi_rx),
        .tap_sw(tap_sw), .defeat_sw(defeat_sw), .tap_tempo_active(tap_act), .panel_level(panel[0]),
        .panel_time(panel[1]), .panel_feedback(panel[2]), .panel_mix(panel[3]), .panel_rate(panel[4]),
        .panel_depth(panel[5]), .nv_ready(nv_ready), .nv_channel(nv_channel), .nv_write_reg(nv_write),
        .nv_data_reg(nv_data), .level_out_reg(outv[0]), .time_out_reg(outv[1]), .feedback_out_reg(outv[2]),
        .mix_out_reg(outv[3]), .rate_out_reg(outv[4]), .depth_out_reg(outv[5]), .waveform_reg(wave),
        .range_fast_reg(rng), .effect_active_reg(eff), .delay_indicator_lamp_reg(lamp), .clock_tick_reg(tick),
        .sysex_valid_reg(sxv), .sysex_data_reg(sxd), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata));
    mcd_midi_src #(.BIT_CYCLES(BITC)) src (.clk_sys(clk_sys), .midi_line(midi_rx));

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        ticks += (tick === 1'b1);
        sxn += (sxv === 1'b1);
        nvw += (nv_write === 1'b1);
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Bands of sixteen, the top two bands share the last shape
    function automatic logic [2:0] wave_exp(input logic [6:0] v);
        return (v[6:4] > 3'h6) ? 3'h6 : v[6:4];
    endfunction

    task automatic test_done();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            failures++;
            test_done();
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    // Frame ends after the stop bit; results land within a few edges
    task automatic settle();
        repeat (4) @(posedge clk_sys);
    endtask

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        test_done();
    end

    initial
    begin
        seed = 32'h000168CD;
        {rstn, tap_sw, defeat_sw, tap_act, nv_ready, hsel, hwrite} = 7'h0;
        {nv_channel, haddr, hwdata, htrans} = 70'h0;
        for (int i = 0; i < 6; i++)
            panel[i] = 14'h0;
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        nv_ready <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            r = rnd();
            panel[i] <= r[13:0];
        end
        @(posedge clk_sys);
        rdchk("status", `MCD_REG_STATUS, 32'h10);
        rdchk("ctrl", `MCD_REG_CTRL, 32'h1);
        rdchk("unmapped", 32'h40, 32'h0);
        for (int i = 0; i < 6; i++)
            chk("panel follow", panel[i], outv[i]);
        src.cc(4'h0, 7'h0C, 7'h40);
        settle();
        chk("lone msb", 32'h2000, outv[1]);
        chk("orange lamp", `MCD_LAMP_ORANGE, lamp);
        src.send(8'h2C);
        src.send(8'h05);
        settle();
        chk("pair", 32'h2005, outv[1]);
        for (int i = 0; i < 6; i++)
        begin
            r = rnd();
            {m, l} = r[13:0];
            src.cc(4'h0, ccn[i], m);
            src.cc(4'h0, ccn[i] + 7'h20, l);
            settle();
            chk("param value", {m, l}, outv[i]);
            rdchk("param reg", `MCD_REG_PARAM0 + 4 * i, {17'h1, m, l});
        end
        keep = outv;
        src.cc(4'h0, 7'h14, 7'h55);
        settle();
        for (int i = 0; i < 6; i++)
            chk("unassigned", keep[i], outv[i]);
        for (int b = 0; b < 8; b++)
        begin
            r = rnd();
            m = {b[2:0], r[3:0]};
            src.cc(4'h0, `MCD_CC_WAVE, m);
            settle();
            chk("wave", wave_exp(m), wave);
        end
        for (int v = 0; v < 2; v++)
        begin
            src.cc(4'h0, `MCD_CC_RANGE, 7'h40 * v);
            src.cc(4'h0, `MCD_CC_BYPASS, 7'h3F + v);
            settle();
            chk("range", v, rng);
            chk("effect", v, eff);
            chk("lamp", v ? `MCD_LAMP_ORANGE : `MCD_LAMP_RED, lamp);
        end
        panel[1] <= panel[1] ^ 14'h1555;
        tap_act <= 1'b1;
        settle();
        chk("panel back", panel[1], outv[1]);
        chk("green lamp", `MCD_LAMP_GREEN, lamp);
        rdchk("param owner", `MCD_REG_PARAM0 + 4, {18'h0, panel[1]});
        tap_act <= 1'b0;
        tap_sw <= 1'b1;
        defeat_sw <= 1'b1;
        src.cc(4'h5, 7'h79, 7'h00);
        settle();
        chk("store writes", 1, nvw);
        chk("store data", 4'h5, nv_data);
        chk("yellow", `MCD_LAMP_YELLOW, lamp);
        ahb(1'b0, `MCD_REG_STATUS, 32'h0);
        chk("channel", 4'h5, rd[3:0]);
        tap_sw <= 1'b0;
        defeat_sw <= 1'b0;
        keep = outv;
        src.cc(4'h0, `MCD_CC_TIME, 7'h11);
        settle();
        chk("other channel", keep[1], outv[1]);
        src.cc(4'h5, `MCD_CC_TIME, 7'h11);
        settle();
        chk("own channel", 32'h0880, outv[1]);
        ahb(1'b1, `MCD_REG_CTRL, 32'h0);
        src.cc(4'h5, `MCD_CC_TIME, 7'h22);
        for (int i = 0; i < 3; i++)
            src.send(`MCD_RT_CLOCK);
        src.send(`MCD_SX_START);
        src.send(8'h11);
        src.send(`MCD_SX_END);
        settle();
        chk("disabled", 32'h0880, outv[1]);
        chk("ticks", 3, ticks);
        rdchk("clock count", `MCD_REG_CLKCNT, 32'h3);
        chk("sysex bytes", 3, sxn);
        chk("sysex last", `MCD_SX_END, sxd);
        ahb(1'b1, `MCD_REG_CTRL, 32'h1);
        rstn <= 1'b0;
        nv_ready <= 1'b0;
        nv_channel <= 4'h5;
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        nv_ready <= 1'b1;
        settle();
        ahb(1'b0, `MCD_REG_STATUS, 32'h0);
        chk("restored channel", 4'h5, rd[3:0]);
        test_done();
    end
endmodule
